//--- hdl/ildo_regs.sv
`timescale 1ns/1ns
// Function
// - state code 4 is off, 5 low-power, 6 and 7 active; 0-3 reserved
// - standby-exit assertion copies the exit-state field into the state field
// - exit-state codes 0 to 3 mean no copy; state stays as it is
// - first regulator control register at 0x42, resets to 0x04
// - second regulator control register resets to 0x24
// - a regulator that is off has its active discharge asserted
// - regulators are controlled independently; a write touches only its own register
// - card rail at 1.8 V runs as regulator, at 3.3 V as switch
// - card rail is actively discharged whenever it is off
module ildo_regs
   import ildo_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [CTRL_W-1:0] reg_wdata,
   input  wire logic              reg_wr_done,
   input  wire logic              reg_rd,
   input  wire logic              standby_exit_pin,
   input  wire logic [2:0]        card_rail_state_in,
   input  wire logic [1:0]        card_rail_vsel_in,
   output logic      [CTRL_W-1:0] reg_rdata_r,
   output logic                   reg_rvalid_r,
   output logic                   reg_wack_r,
   output logic                   reg_addr_err_r,
   output logic                   ldo_a_enable_r,
   output logic                   ldo_a_low_power_r,
   output logic                   ldo_a_discharge_r,
   output logic                   ldo_a_copied_r,
   output logic                   ldo_a_exit_armed_r,
   output logic                   ldo_b_enable_r,
   output logic                   ldo_b_low_power_r,
   output logic                   ldo_b_discharge_r,
   output logic                   ldo_b_copied_r,
   output logic                   ldo_b_exit_armed_r,
   output logic      [1:0]        ldo_b_voltage_select_r,
   output logic      [11:0]       ldo_b_vout_mv_r,
   output logic                   card_rail_enable_r,
   output logic                   card_rail_low_power_r,
   output logic                   card_rail_ldo_mode_r,
   output logic                   card_rail_switch_mode_r,
   output logic                   card_rail_discharge_r,
   output logic      [11:0]       card_rail_vout_mv_r,
   output logic                   card_rail_live_vsel_r
);

   logic [CTRL_W-1:0] ldo_a_ctrl;
   logic [CTRL_W-1:0] ldo_b_ctrl;
   logic              sel_a;
   logic              sel_b;
   logic              wr_a;
   logic              wr_b;
   logic              exit_pin_r;
   logic              exit_rise;
   logic [CTRL_W-1:0] rdata_nxt;
   ildo_mode_type     card_mode;
   logic              card_sel_ok;

   // address decode; each regulator has its own strobe
   assign sel_a = (reg_addr == LDO_A_CTRL_ADDR);
   assign sel_b = (reg_addr == LDO_B_CTRL_ADDR);
   assign wr_a  = reg_wr_done && sel_a;
   assign wr_b  = reg_wr_done && sel_b;

   // a held pin copies once; a level copy would overwrite every later host write
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         exit_pin_r <= 1'b0;
      end else begin
         exit_pin_r <= standby_exit_pin;
      end
   end

   assign exit_rise = standby_exit_pin && !exit_pin_r;

   ildo_chan #(
      .RESET_VAL (LDO_A_CTRL_RESET),
      .WMASK     (LDO_A_WMASK)
   ) u_ldo_a (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .wr_en        (wr_a),
      .wdata        (reg_wdata),
      .exit_rise    (exit_rise),
      .ctrl_r       (ldo_a_ctrl),
      .enable_r     (ldo_a_enable_r),
      .low_power_r  (ldo_a_low_power_r),
      .discharge_r  (ldo_a_discharge_r),
      .copied_r     (ldo_a_copied_r),
      .exit_armed_r (ldo_a_exit_armed_r)
   );

   ildo_chan #(
      .RESET_VAL (LDO_B_CTRL_RESET),
      .WMASK     (LDO_B_WMASK)
   ) u_ldo_b (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .wr_en        (wr_b),
      .wdata        (reg_wdata),
      .exit_rise    (exit_rise),
      .ctrl_r       (ldo_b_ctrl),
      .enable_r     (ldo_b_enable_r),
      .low_power_r  (ldo_b_low_power_r),
      .discharge_r  (ldo_b_discharge_r),
      .copied_r     (ldo_b_copied_r),
      .exit_armed_r (ldo_b_exit_armed_r)
   );

   // voltage follows the stored select one cycle after the write lands
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ldo_b_voltage_select_r <= LDO_B_CTRL_RESET[VSEL_MSB:VSEL_LSB];
         ldo_b_vout_mv_r        <= ildo_vsel_mv(LDO_B_CTRL_RESET[VSEL_MSB:VSEL_LSB]);
      end else begin
         ldo_b_voltage_select_r <= ldo_b_ctrl[VSEL_MSB:VSEL_LSB];
         ldo_b_vout_mv_r        <= ildo_vsel_mv(ldo_b_ctrl[VSEL_MSB:VSEL_LSB]);
      end
   end

   // read path: registered so that every output comes from a flop
   always_comb begin
      rdata_nxt = UNMAPPED_RDATA;
      if (sel_a) begin
         rdata_nxt = ldo_a_ctrl & LDO_A_WMASK;
      end else if (sel_b) begin
         rdata_nxt = ldo_b_ctrl;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_r  <= UNMAPPED_RDATA;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_wack_r     <= 1'b0;
         reg_addr_err_r <= 1'b0;
      end else begin
         reg_wack_r     <= reg_wr_done;
         reg_addr_err_r <= (reg_wr_done || reg_rd) && !sel_a && !sel_b;
      end
   end

   // card-slot rail: control comes from its own register outside this block
   assign card_mode   = ildo_decode(card_rail_state_in);
   assign card_sel_ok = (card_rail_vsel_in == CARD_SEL_1V8) ||
                        (card_rail_vsel_in == CARD_SEL_3V3);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         card_rail_enable_r    <= 1'b0;
         card_rail_low_power_r <= 1'b0;
         card_rail_discharge_r <= 1'b1;
      end else begin
         case (card_mode)
            ILDO_MODE_OFF: begin
               card_rail_enable_r    <= 1'b0;
               card_rail_low_power_r <= 1'b0;
               card_rail_discharge_r <= 1'b1;
            end
            ILDO_MODE_LOW_POWER: begin
               card_rail_enable_r    <= 1'b1;
               card_rail_low_power_r <= 1'b1;
               card_rail_discharge_r <= 1'b0;
            end
            ILDO_MODE_ACTIVE: begin
               card_rail_enable_r    <= 1'b1;
               card_rail_low_power_r <= 1'b0;
               card_rail_discharge_r <= 1'b0;
            end
            default: begin
               card_rail_enable_r    <= card_rail_enable_r;
               card_rail_low_power_r <= card_rail_low_power_r;
               card_rail_discharge_r <= card_rail_discharge_r;
            end
         endcase
      end
   end

   // reset assumes the 3.3 V switch path, which is how a new card starts
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         card_rail_ldo_mode_r    <= 1'b0;
         card_rail_switch_mode_r <= 1'b1;
         card_rail_vout_mv_r     <= CARD_3V3_MV;
      end else if (card_sel_ok) begin
         card_rail_ldo_mode_r    <= (card_rail_vsel_in == CARD_SEL_1V8);
         card_rail_switch_mode_r <= (card_rail_vsel_in == CARD_SEL_3V3);
         card_rail_vout_mv_r     <= (card_rail_vsel_in == CARD_SEL_1V8) ?
                                    CARD_1V8_MV : CARD_3V3_MV;
      end
   end

   // flags a select change while the rail is on; the host must switch it off first
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         card_rail_live_vsel_r <= 1'b0;
      end else if (card_sel_ok && card_rail_enable_r &&
                   (card_rail_ldo_mode_r != (card_rail_vsel_in == CARD_SEL_1V8))) begin
         card_rail_live_vsel_r <= 1'b1;
      end else if (!card_rail_enable_r) begin
         card_rail_live_vsel_r <= 1'b0;
      end
   end

endmodule : ildo_regs

//--- hdl/ildo_pkg.sv
package ildo_pkg;

   localparam int CTRL_W = 8;
   localparam int ADDR_W = 8;

   localparam logic [ADDR_W-1:0] LDO_A_CTRL_ADDR  = 8'h42;
   localparam logic [ADDR_W-1:0] LDO_B_CTRL_ADDR  = 8'h48;
   localparam logic [CTRL_W-1:0] LDO_A_CTRL_RESET = 8'h04;
   localparam logic [CTRL_W-1:0] LDO_B_CTRL_RESET = 8'h24;
   // writable bits: the second regulator adds the voltage select on top
   localparam logic [CTRL_W-1:0] LDO_A_WMASK      = 8'h3F;
   localparam logic [CTRL_W-1:0] LDO_B_WMASK      = 8'hFF;
   localparam logic [CTRL_W-1:0] UNMAPPED_RDATA   = 8'h00;

   localparam int STATE_LSB = 0;
   localparam int STATE_MSB = 2;
   localparam int EXIT_LSB  = 3;
   localparam int EXIT_MSB  = 5;
   localparam int VSEL_LSB  = 6;
   localparam int VSEL_MSB  = 7;

   localparam logic [2:0] CODE_OFF        = 3'h4;
   localparam logic [2:0] CODE_LOW_POWER  = 3'h5;
   localparam logic [2:0] CODE_ACTIVE     = 3'h6;
   localparam logic [2:0] CODE_ACTIVE_ALT = 3'h7;

   // second imaging regulator output levels in millivolts
   localparam logic [11:0] VSEL0_MV = 12'h5DC;
   localparam logic [11:0] VSEL1_MV = 12'hA8C;
   localparam logic [11:0] VSEL2_MV = 12'hAF0;
   localparam logic [11:0] VSEL3_MV = 12'hB54;

   // card-slot rail voltage select codes and levels
   localparam logic [1:0]  CARD_SEL_1V8 = 2'h0;
   localparam logic [1:0]  CARD_SEL_3V3 = 2'h1;
   localparam logic [11:0] CARD_1V8_MV  = 12'h708;
   localparam logic [11:0] CARD_3V3_MV  = 12'hCE4;

   typedef enum logic [1:0] {
      ILDO_MODE_OFF,
      ILDO_MODE_LOW_POWER,
      ILDO_MODE_ACTIVE,
      ILDO_MODE_RESERVED
   } ildo_mode_type;

   function automatic ildo_mode_type ildo_decode(input logic [2:0] code);
      case (code)
         CODE_OFF:        ildo_decode = ILDO_MODE_OFF;
         CODE_LOW_POWER:  ildo_decode = ILDO_MODE_LOW_POWER;
         CODE_ACTIVE:     ildo_decode = ILDO_MODE_ACTIVE;
         CODE_ACTIVE_ALT: ildo_decode = ILDO_MODE_ACTIVE;
         default:         ildo_decode = ILDO_MODE_RESERVED;
      endcase
   endfunction : ildo_decode

   function automatic logic [11:0] ildo_vsel_mv(input logic [1:0] sel);
      case (sel)
         2'h0:    ildo_vsel_mv = VSEL0_MV;
         2'h1:    ildo_vsel_mv = VSEL1_MV;
         2'h2:    ildo_vsel_mv = VSEL2_MV;
         default: ildo_vsel_mv = VSEL3_MV;
      endcase
   endfunction : ildo_vsel_mv

endpackage : ildo_pkg

//--- hdl/ildo_chan.sv
`timescale 1ns/1ns
module ildo_chan
   import ildo_pkg::*;
#(
   parameter logic [CTRL_W-1:0] RESET_VAL = LDO_A_CTRL_RESET,
   parameter logic [CTRL_W-1:0] WMASK     = LDO_A_WMASK
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              wr_en,
   input  wire logic [CTRL_W-1:0] wdata,
   input  wire logic              exit_rise,
   output logic      [CTRL_W-1:0] ctrl_r,
   output logic                   enable_r,
   output logic                   low_power_r,
   output logic                   discharge_r,
   output logic                   copied_r,
   output logic                   exit_armed_r
);

   logic [CTRL_W-1:0] ctrl_nxt;
   logic [2:0]        exit_code;
   logic              do_copy;
   ildo_mode_type     mode;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_en) begin
         ctrl_nxt = (wdata & WMASK) | (ctrl_r & ~WMASK);
      end
      exit_code = ctrl_nxt[EXIT_MSB:EXIT_LSB];
      // reserved exit codes mean do not copy
      do_copy = exit_rise && (ildo_decode(exit_code) != ILDO_MODE_RESERVED);
      if (do_copy) begin
         ctrl_nxt[STATE_MSB:STATE_LSB] = exit_code;
      end
      mode = ildo_decode(ctrl_nxt[STATE_MSB:STATE_LSB]);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= RESET_VAL;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // a reserved state code keeps the last legal operating state
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         enable_r    <= 1'b0;
         low_power_r <= 1'b0;
         discharge_r <= 1'b1;
      end else begin
         case (mode)
            ILDO_MODE_OFF: begin
               enable_r    <= 1'b0;
               low_power_r <= 1'b0;
               discharge_r <= 1'b1;
            end
            ILDO_MODE_LOW_POWER: begin
               enable_r    <= 1'b1;
               low_power_r <= 1'b1;
               discharge_r <= 1'b0;
            end
            ILDO_MODE_ACTIVE: begin
               enable_r    <= 1'b1;
               low_power_r <= 1'b0;
               discharge_r <= 1'b0;
            end
            default: begin
               enable_r    <= enable_r;
               low_power_r <= low_power_r;
               discharge_r <= discharge_r;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         copied_r     <= 1'b0;
         exit_armed_r <= 1'b0;
      end else begin
         copied_r <= do_copy;
         if (wr_en) begin
            exit_armed_r <= 1'b1;
         end
      end
   end

endmodule : ildo_chan

//--- testbench/ildo_regs_props.sv
`timescale 1ns/1ns
module ildo_regs_checker
   import ildo_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [CTRL_W-1:0] reg_wdata,
   input wire logic              reg_wr_done,
   input wire logic              reg_rd,
   input wire logic [1:0]        card_rail_vsel_in,
   input wire logic [CTRL_W-1:0] reg_rdata_r,
   input wire logic              reg_wack_r,
   input wire logic              reg_addr_err_r,
   input wire logic              ldo_a_enable_r,
   input wire logic              ldo_a_discharge_r,
   input wire logic              ldo_b_enable_r,
   input wire logic              ldo_b_discharge_r,
   input wire logic [1:0]        ldo_b_voltage_select_r,
   input wire logic              card_rail_enable_r,
   input wire logic              card_rail_discharge_r,
   input wire logic              card_rail_ldo_mode_r,
   input wire logic              card_rail_switch_mode_r,
   input wire logic [11:0]       card_rail_vout_mv_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic mapped;
   assign mapped = (reg_addr == LDO_A_CTRL_ADDR) || (reg_addr == LDO_B_CTRL_ADDR);
   AST_WACK: assert property (reg_wr_done |=> reg_wack_r)
      else $error("write not acknowledged");
   AST_ADDR_ERR: assert property ((reg_wr_done || reg_rd) |=> reg_addr_err_r == !$past(mapped))
      else $error("address error flag wrong");
   AST_RSVD_A: assert property (reg_rd && reg_addr == LDO_A_CTRL_ADDR |=> reg_rdata_r[7:6] == 2'h0)
      else $error("reserved bits of first regulator not zero");
   AST_DIS_A: assert property (ldo_a_discharge_r != ldo_a_enable_r)
      else $error("first regulator discharge wrong");
   AST_DIS_B: assert property (ldo_b_discharge_r != ldo_b_enable_r)
      else $error("second regulator discharge wrong");
   AST_DIS_C: assert property (card_rail_discharge_r != card_rail_enable_r)
      else $error("card rail discharge wrong");
   AST_CARD_LDO: assert property (card_rail_vsel_in == CARD_SEL_1V8 |=> card_rail_ldo_mode_r &&
      !card_rail_switch_mode_r && card_rail_vout_mv_r == CARD_1V8_MV) else $error("card ldo mode wrong");
   AST_CARD_SW: assert property (card_rail_vsel_in == CARD_SEL_3V3 |=> card_rail_switch_mode_r &&
      !card_rail_ldo_mode_r && card_rail_vout_mv_r == CARD_3V3_MV) else $error("card switch mode wrong");
   AST_VSEL_B: assert property (reg_wr_done && reg_addr == LDO_B_CTRL_ADDR |=>
      ##1 ldo_b_voltage_select_r == $past(reg_wdata[7:6], 2)) else $error("voltage select not applied");
endmodule : ildo_regs_checker

bind ildo_regs ildo_regs_checker i_ildo_regs_checker (.*);

//--- testbench/ildo_host_model.sv
`timescale 1ns/1ns
module ildo_host_model
   import ildo_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic [CTRL_W-1:0] reg_rdata_r,
   input  wire logic              reg_rvalid_r,
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [CTRL_W-1:0] reg_wdata,
   output logic                   reg_wr_done,
   output logic                   reg_rd
);
   initial begin
      reg_addr    = 8'h00;
      reg_wdata   = 8'h00;
      reg_wr_done = 1'b0;
      reg_rd      = 1'b0;
   end
   // released lines flip so a stale address or byte never looks live
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] d);
      @(negedge core_clk);
      reg_addr    = a;
      reg_wdata   = d;
      reg_wr_done = 1'b1;
      @(negedge core_clk);
      reg_wr_done = 1'b0;
      reg_addr    = ~a;
      reg_wdata   = ~d;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [CTRL_W-1:0] d, output logic v);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      d        = reg_rdata_r;
      v        = reg_rvalid_r;
      reg_rd   = 1'b0;
      reg_addr = ~a;
   endtask : rd
endmodule : ildo_host_model

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench
   import ildo_pkg::*;
;
   logic              core_clk, nrst, standby_exit_pin, reg_wr_done, reg_rd, reg_rvalid_r;
   logic              reg_addr_err_r, ldo_a_enable_r, ldo_a_low_power_r, ldo_a_copied_r;
   logic              ldo_b_enable_r, ldo_b_low_power_r, ldo_b_copied_r, card_rail_enable_r;
   logic              card_rail_discharge_r, card_rail_ldo_mode_r, ca, cb;
   logic              ldo_a_exit_armed_r, ldo_b_exit_armed_r;
   logic              card_rail_low_power_r, card_rail_live_vsel_r;
   logic [2:0]        card_rail_state_in;
   logic [1:0]        card_rail_vsel_in;
   logic [ADDR_W-1:0] reg_addr;
   logic [CTRL_W-1:0] reg_wdata, reg_rdata_r;
   logic [11:0]       ldo_b_vout_mv_r, card_rail_vout_mv_r;
   logic [11:0]       vout_tab [4] = '{VSEL0_MV, VSEL1_MV, VSEL2_MV, VSEL3_MV};
   int                miscompares = 0;
   int                total_checks = 0;

   ildo_host_model i_ildo_host_model (.core_clk, .reg_rdata_r, .reg_rvalid_r, .reg_addr,
      .reg_wdata, .reg_wr_done, .reg_rd);
   ildo_regs i_ildo_regs (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr_done, .reg_rd,
      .standby_exit_pin, .card_rail_state_in, .card_rail_vsel_in, .reg_rdata_r, .reg_rvalid_r,
      .reg_wack_r(), .reg_addr_err_r, .ldo_a_enable_r, .ldo_a_low_power_r, .ldo_a_discharge_r(),
      .ldo_a_copied_r, .ldo_a_exit_armed_r, .ldo_b_enable_r, .ldo_b_low_power_r,
      .ldo_b_discharge_r(), .ldo_b_copied_r, .ldo_b_exit_armed_r, .ldo_b_voltage_select_r(),
      .ldo_b_vout_mv_r, .card_rail_enable_r, .card_rail_low_power_r, .card_rail_ldo_mode_r,
      .card_rail_switch_mode_r(), .card_rail_discharge_r, .card_rail_vout_mv_r,
      .card_rail_live_vsel_r);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chkb(input string nm, input logic exp, input logic got);
      chk(nm, {11'h000, exp}, {11'h000, got});
   endtask : chkb
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] exp);
      logic [CTRL_W-1:0] d;
      logic              v;
      i_ildo_host_model.rd(a, d, v);
      chkb("rvalid", 1'b1, v);
      chk("rdata", {4'h0, exp}, {4'h0, d});
   endtask : rchk
   // voltage outputs settle one edge after the register, hence the extra cycle
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] d);
      i_ildo_host_model.wr(a, d);
      @(negedge core_clk);
   endtask : wr
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   initial begin
      repeat (3000) @(posedge core_clk);
      miscompares++;
      complete_run();
   end

   initial begin
      nrst = 1'b0;
      standby_exit_pin = 1'b0;
      card_rail_state_in = 3'h4;
      card_rail_vsel_in = CARD_SEL_3V3;
      repeat (6) @(negedge core_clk);
      nrst = 1'b1;
      rchk(LDO_A_CTRL_ADDR, 8'h04);
      rchk(LDO_B_CTRL_ADDR, 8'h24);
      chkb("a_armed", 1'b0, ldo_a_exit_armed_r);
      chk("b_vout", VSEL0_MV, ldo_b_vout_mv_r);
      wr(LDO_A_CTRL_ADDR, 8'hFE);
      rchk(LDO_A_CTRL_ADDR, 8'h3E);
      chkb("a_en", 1'b1, ldo_a_enable_r);
      chkb("b_en", 1'b0, ldo_b_enable_r);
      chkb("a_armed", 1'b1, ldo_a_exit_armed_r);
      chkb("b_armed", 1'b0, ldo_b_exit_armed_r);
      for (int i = 0; i < 4; i++) begin
         wr(LDO_B_CTRL_ADDR, {i[1:0], 3'h4, 3'h4 + i[2:0]});
         chkb("b_en", i != 0, ldo_b_enable_r);
         chkb("b_lp", i == 1, ldo_b_low_power_r);
         chk("b_vout", vout_tab[i], ldo_b_vout_mv_r);
         rchk(LDO_B_CTRL_ADDR, {i[1:0], 3'h4, 3'h4 + i[2:0]});
      end
      chkb("a_en", 1'b1, ldo_a_enable_r);
      chkb("b_armed", 1'b1, ldo_b_exit_armed_r);
      wr(LDO_B_CTRL_ADDR, 8'hE2);
      chkb("b_en", 1'b1, ldo_b_enable_r);
      wr(LDO_A_CTRL_ADDR, 8'h2C);
      wr(LDO_B_CTRL_ADDR, 8'h16);
      chkb("a_en", 1'b0, ldo_a_enable_r);
      ca = 1'b0;
      cb = 1'b0;
      standby_exit_pin = 1'b1;
      repeat (4) begin
         @(negedge core_clk);
         ca = ca | ldo_a_copied_r;
         cb = cb | ldo_b_copied_r;
      end
      chkb("a_copy", 1'b1, ca);
      chkb("b_copy", 1'b0, cb);
      chkb("a_lp", 1'b1, ldo_a_low_power_r);
      chkb("b_en", 1'b1, ldo_b_enable_r);
      rchk(LDO_A_CTRL_ADDR, 8'h2D);
      standby_exit_pin = 1'b0;
      rchk(8'h43, 8'h00);
      chkb("addr_err", 1'b1, reg_addr_err_r);
      card_rail_state_in = 3'h6;
      repeat (2) @(negedge core_clk);
      chkb("card_en", 1'b1, card_rail_enable_r);
      chk("card_vout", CARD_3V3_MV, card_rail_vout_mv_r);
      card_rail_state_in = 3'h4;
      repeat (2) @(negedge core_clk);
      chkb("card_dis", 1'b1, card_rail_discharge_r);
      card_rail_vsel_in = CARD_SEL_1V8;
      repeat (2) @(negedge core_clk);
      card_rail_state_in = 3'h6;
      repeat (2) @(negedge core_clk);
      chkb("card_ldo", 1'b1, card_rail_ldo_mode_r);
      chk("card_vout", CARD_1V8_MV, card_rail_vout_mv_r);
      chkb("live_vsel", 1'b0, card_rail_live_vsel_r);
      card_rail_state_in = 3'h5;
      card_rail_vsel_in = 2'h2;
      repeat (2) @(negedge core_clk);
      chkb("card_lp", 1'b1, card_rail_low_power_r);
      chkb("card_dis", 1'b0, card_rail_discharge_r);
      chkb("card_ldo", 1'b1, card_rail_ldo_mode_r);
      // out-of-order select change while on must raise the flag
      card_rail_vsel_in = CARD_SEL_3V3;
      repeat (2) @(negedge core_clk);
      chkb("live_vsel", 1'b1, card_rail_live_vsel_r);
      chk("card_vout", CARD_3V3_MV, card_rail_vout_mv_r);
      card_rail_state_in = 3'h4;
      repeat (2) @(negedge core_clk);
      chkb("live_vsel", 1'b0, card_rail_live_vsel_r);
      complete_run();
   end
endmodule : testbench
